// file: verilog/smsm_core.sv
// secure memory access state manager: apb registers, access gating, session state
`timescale 1ns/100ps
module smsm_core
    import smsm_pkg::*;
#(
    parameter int ATT_MAX = ATT_MAX_DEF,
    parameter int WR_CYC = EE_WR_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmd_valid,
    input wire smsm_cmd_t cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output smsm_rsp_t rsp,
    output logic pw_cipher,
    input wire logic ee_pending,
    output logic ee_wr,
    output logic ee_to_buf,
    output logic ee_from_buf
);
    if (ATT_MAX < 1 || ATT_MAX >= (1 << CNT_W)) begin : g_bad
        $error("smsm_core: ATT_MAX out of counter range");
    end
    localparam logic [CNT_W-1:0] ATT_LIM = CNT_W'(ATT_MAX);
    typedef enum logic [1:0] {
        M_IDLE = 2'b01,
        M_WAIT = 2'b10
    } smsm_mst_t;
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    smsm_mst_t st;
    logic auth;
    logic enc;
    logic pw_act;
    logic [2:0] pw_set;
    logic pw_wr;
    logic cfg_unlock;
    logic tear_en;
    logic pers;
    logic [31:0] zmask;
    logic [CNT_W-1:0] pw_cnt [PW_SETS];
    logic [CNT_W-1:0] au_cnt;
    logic [CNT_W*PW_SETS-1:0] cnt_flat;
    logic t_busy;
    logic t_done;
    logic acc;
    logic is_wr;
    logic is_rd;
    logic code_hit;
    logic pw_lock;
    logic au_lock;
    logic mac_bad;
    logic too_long;
    logic zone_ok;
    logic grant;
    logic t_start;
    logic next_ok;
    logic ends;
    logic apb_wr;
    logic hit;
    logic [31:0] next_rd;
    assign acc = cmd_valid && cmd_ready;
    assign t_start = acc && is_wr && grant;
    assign ends = acc && (cmd.op == OP_UNSEL || cmd.op == OP_QUIET);
    // ------------------------------------------------------------
    // command decode and access gating
    // ------------------------------------------------------------
    always_comb begin
        is_wr = cmd.op == OP_WRITE;
        is_rd = cmd.op == OP_READ;
        code_hit = cmd.pw_val == TRANSPORT_CODE;
        pw_lock = pw_cnt[cmd.pw_set] >= ATT_LIM;
        au_lock = au_cnt >= ATT_LIM;
        // standard mode ignores the checksum entirely
        mac_bad = is_wr && auth && !(cmd.mac_sent && cmd.mac_ok);
        too_long = is_wr && tear_en && cmd.len > TEAR_PAGE;
        if (cmd.cfg) begin
            zone_ok = cfg_unlock;
        end else if (!pers) begin
            zone_ok = 1'b1;
        end else begin
            zone_ok = (!zmask[cmd.zone] || enc)
                && (!zmask[ZM_PW_LSB + int'(cmd.zone)]
                || (pw_act && pw_set == cmd.zone[2:0] && (pw_wr || is_rd)));
        end
        grant = zone_ok && !mac_bad && !too_long;
        case (cmd.op)
            OP_READ: next_ok = grant;
            OP_CHKPW: next_ok = code_hit || (cmd.ok && !pw_lock);
            OP_AUTH: next_ok = cmd.ok && !au_lock;
            OP_ENC: next_ok = cmd.ok && auth;
            OP_UNSEL, OP_QUIET: next_ok = 1'b1;
            default: next_ok = 1'b0;
        endcase
    end
    // ------------------------------------------------------------
    // authentication and encryption state
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auth <= 1'b0;
            enc <= 1'b0;
        end else if (acc) begin
            case (cmd.op)
                OP_AUTH: begin
                    auth <= cmd.ok && !au_lock;
                    enc <= 1'b0;
                end
                OP_ENC: enc <= cmd.ok && auth;
                OP_WRITE: begin
                    if (mac_bad) begin
                        auth <= 1'b0;
                        enc <= 1'b0;
                    end
                end
                OP_UNSEL, OP_QUIET: begin
                    auth <= 1'b0;
                    enc <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // active password; a new presentation always replaces the old one
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_act <= 1'b0;
            pw_set <= 3'h0;
            pw_wr <= 1'b0;
            cfg_unlock <= 1'b0;
        end else if (acc && cmd.op == OP_CHKPW) begin
            cfg_unlock <= code_hit;
            pw_act <= !code_hit && cmd.ok && !pw_lock;
            pw_set <= cmd.pw_set;
            pw_wr <= cmd.pw_wr;
        end else if (ends) begin
            pw_act <= 1'b0;
            cfg_unlock <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_cipher <= 1'b0;
        end else begin
            pw_cipher <= auth;
        end
    end
    // ------------------------------------------------------------
    // attempt counters; they only live as long as the supply does
    // ------------------------------------------------------------
    for (genvar i = 0; i < PW_SETS; i++) begin : g_cnt
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pw_cnt[i] <= '0;
            end else if (acc && cmd.op == OP_CHKPW && !code_hit && cmd.pw_set == 3'(i) && !pw_lock) begin
                pw_cnt[i] <= cmd.ok ? '0 : pw_cnt[i] + CNT_W'(1);
            end
        end
        assign cnt_flat[i*CNT_W +: CNT_W] = pw_cnt[i];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            au_cnt <= '0;
        end else if (acc && cmd.op == OP_AUTH && !au_lock) begin
            au_cnt <= cmd.ok ? '0 : au_cnt + CNT_W'(1);
        end
    end
    // ------------------------------------------------------------
    // command flow
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= M_IDLE;
        end else begin
            case (st)
                M_IDLE: begin
                    if (t_start) begin
                        st <= M_WAIT;
                    end
                end
                M_WAIT: begin
                    if (t_done) begin
                        st <= M_IDLE;
                    end
                end
                default: st <= M_IDLE;
            endcase
        end
    end
    // ready drops for at least a cycle after each command (until the write ends for a granted write) so decode sees settled state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= st == M_IDLE && !t_busy && !acc;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= (acc && !t_start) || (st == M_WAIT && t_done);
            if (st == M_WAIT && t_done) begin
                rsp.ok <= 1'b1;
            end else if (acc) begin
                rsp.ok <= next_ok;
                rsp.crypt <= enc && (is_rd || is_wr || cmd.op == OP_CHKPW);
            end
        end
    end
    smsm_tear #(
        .WR_CYC(WR_CYC)
    ) u_tear (
        .pclk(pclk),
        .presetn(presetn),
        .start(t_start),
        .tear_en(tear_en),
        .nv_pending(ee_pending),
        .busy(t_busy),
        .done(t_done),
        .ee_wr(ee_wr),
        .ee_to_buf(ee_to_buf),
        .ee_from_buf(ee_from_buf)
    );
    // ------------------------------------------------------------
    // apb slave: answers in the first access cycle
    // ------------------------------------------------------------
    assign apb_wr = psel && penable && pready && pwrite;
    always_comb begin
        hit = 1'b1;
        case (paddr)
            A_CTRL: next_rd = {30'h0, pers, tear_en};
            A_ZMASK: next_rd = zmask;
            A_STATUS: next_rd = {22'h0, t_busy, cfg_unlock, pw_wr, pw_set, pw_act, pw_cipher, enc, auth};
            A_PWCNT: next_rd = cnt_flat;
            A_AUCNT: next_rd = {28'h0, au_cnt};
            default: begin
                next_rd = 32'h0;
                hit = 1'b0;
            end
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                pslverr <= !hit;
                prdata <= pwrite ? 32'h0 : next_rd;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tear_en <= 1'b0;
            pers <= 1'b0;
            zmask <= RST_ZMASK;
        end else if (apb_wr && paddr == A_CTRL) begin
            tear_en <= pwdata[CTRL_TEAR];
            pers <= pwdata[CTRL_PERS];
        end else if (apb_wr && paddr == A_ZMASK) begin
            zmask <= pwdata;
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_acc(smsm_op_t o);
        acc && cmd.op == o;
    endsequence
    sequence s_refused;
        rsp_valid && !rsp.ok;
    endsequence
    AST_TEAR_PAGE: assert property (@(posedge pclk) disable iff (!presetn)
        s_acc(OP_WRITE) and (tear_en && cmd.len > TEAR_PAGE) |=> s_refused and !ee_wr)
        else $error("oversize anti-tearing write accepted");
    AST_PW_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        pw_act && !(acc && (cmd.op == OP_CHKPW || ends)) |=> pw_act && $stable(pw_set))
        else $error("password dropped without cause");
    AST_WRPW_READ: assert property (@(posedge pclk) disable iff (!presetn)
        s_acc(OP_READ) and (pers && !cmd.cfg && !zmask[cmd.zone] && pw_act && pw_wr
        && pw_set == cmd.zone[2:0]) |=> rsp_valid && rsp.ok)
        else $error("write password did not grant read");
    AST_CIPHER: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(auth) |=> pw_cipher ##1 pw_cipher || !auth)
        else $error("password cipher not on while authenticated");
    AST_AUTH_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
        s_acc(OP_AUTH) and !cmd.ok |=> !auth && !enc ##1 !auth || $past(acc))
        else $error("failed authentication kept old state");
    AST_ENC_ZONE: assert property (@(posedge pclk) disable iff (!presetn)
        s_acc(OP_READ) and (pers && !cmd.cfg && zmask[cmd.zone] && !enc) |=> s_refused)
        else $error("key zone read without encryption");
    AST_SESSION_END: assert property (@(posedge pclk) disable iff (!presetn)
        ends |=> !auth && !enc && !pw_act && !cfg_unlock && rsp_valid && rsp.ok)
        else $error("unselect or quiesce left state");
    AST_ENC_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
        s_acc(OP_ENC) and !cmd.ok |=> !enc ##1 !(rsp_valid && rsp.crypt) || enc)
        else $error("encryption kept after failed activation");
    AST_STD_NO_MAC: assert property (@(posedge pclk) disable iff (!presetn)
        s_acc(OP_WRITE) and (!auth && !pers && !cmd.cfg && !too_long && !cmd.mac_sent) |=> ee_wr)
        else $error("standard write blocked by missing checksum");
    AST_MAC_BAD: assert property (@(posedge pclk) disable iff (!presetn)
        s_acc(OP_WRITE) and (auth && !cmd.mac_ok) |=> s_refused and !auth and !enc and !ee_wr)
        else $error("code mismatch did not abandon write");
    AST_CFG_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        acc && (is_rd || is_wr) && cmd.cfg && !cfg_unlock |=> !ee_wr && !(rsp_valid && rsp.ok))
        else $error("configuration access without transport code");
    AST_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
        s_acc(OP_AUTH) and (!cmd.ok && !au_lock) |=> au_cnt == $past(au_cnt) + CNT_W'(1))
        else $error("authentication attempt not counted");
endmodule

// file: verilog/smsm_pkg.sv
// shared constants and types for the secure memory access state manager
package smsm_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int EE_WR_NS = 1000;
    localparam int EE_WR_CYC = (EE_WR_NS + CLK_NS - 1) / CLK_NS;
    // ------------------------------------------------------------
    // security constants
    // ------------------------------------------------------------
    localparam logic [23:0] TRANSPORT_CODE = 24'h6078af;
    localparam logic [5:0] TEAR_PAGE = 6'h08;
    localparam int PW_SETS = 8;
    localparam int CNT_W = 4;
    localparam int ATT_MAX_DEF = 7;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_ZMASK = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_PWCNT = 8'h0c;
    localparam logic [7:0] A_AUCNT = 8'h10;
    localparam int CTRL_TEAR = 0;
    localparam int CTRL_PERS = 1;
    localparam int ZM_PW_LSB = 16;
    localparam logic [31:0] RST_ZMASK = 32'h0000_0000;
    // ------------------------------------------------------------
    // command carrier
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_CHKPW = 3'h0,
        OP_AUTH = 3'h1,
        OP_ENC = 3'h2,
        OP_READ = 3'h3,
        OP_WRITE = 3'h4,
        OP_UNSEL = 3'h5,
        OP_QUIET = 3'h6
    } smsm_op_t;
    typedef struct packed {
        smsm_op_t op;
        logic cfg;
        logic [3:0] zone;
        logic [2:0] pw_set;
        logic pw_wr;
        logic [23:0] pw_val;
        logic ok;
        logic mac_sent;
        logic mac_ok;
        logic [5:0] len;
    } smsm_cmd_t;
    typedef struct packed {
        logic ok;
        logic crypt;
    } smsm_rsp_t;
endpackage

// file: verilog/smsm_tear.sv
// anti-tearing write sequencer with power-up recovery
`timescale 1ns/100ps
module smsm_tear
    import smsm_pkg::*;
#(
    parameter int WR_CYC = EE_WR_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic tear_en,
    input wire logic nv_pending,
    output logic busy,
    output logic done,
    output logic ee_wr,
    output logic ee_to_buf,
    output logic ee_from_buf
);
    localparam int TW = $clog2(WR_CYC + 1);
    if (WR_CYC < 1) begin : g_bad
        $error("smsm_tear: WR_CYC must be at least 1");
    end
    typedef enum logic [3:0] {
        T_IDLE = 4'b0001,
        T_BUF = 4'b0010,
        T_COPY = 4'b0100,
        T_REC = 4'b1000
    } smsm_tst_t;
    smsm_tst_t st;
    smsm_tst_t next_st;
    logic [TW-1:0] tmr;
    logic started;
    logic buf_used;
    logic tick;
    assign tick = tmr == TW'(WR_CYC - 1);
    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        case (st)
            T_IDLE: begin
                if (!started && nv_pending) begin
                    next_st = T_REC;
                end else if (start) begin
                    next_st = tear_en ? T_BUF : T_COPY;
                end
            end
            T_BUF: begin
                if (tick) begin
                    next_st = T_COPY;
                end
            end
            T_COPY, T_REC: begin
                if (tick) begin
                    next_st = T_IDLE;
                end
            end
            default: next_st = T_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= T_IDLE;
            started <= 1'b0;
        end else begin
            st <= next_st;
            started <= 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr <= '0;
        end else if (st == T_IDLE || tick) begin
            tmr <= '0;
        end else begin
            tmr <= tmr + TW'(1);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_used <= 1'b0;
        end else if (st == T_IDLE) begin
            buf_used <= next_st == T_BUF || next_st == T_REC;
        end
    end
    // ------------------------------------------------------------
    // outputs; busy starts high so no command slips in before recovery
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b1;
            done <= 1'b0;
            ee_wr <= 1'b0;
            ee_to_buf <= 1'b0;
            ee_from_buf <= 1'b0;
        end else begin
            busy <= next_st != T_IDLE;
            done <= st == T_COPY && tick;
            ee_wr <= next_st != T_IDLE;
            ee_to_buf <= next_st == T_BUF;
            ee_from_buf <= next_st == T_REC || (next_st == T_COPY && (buf_used || st == T_BUF));
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_BUF_THEN_COPY: assert property (@(posedge pclk) disable iff (!presetn)
        st == T_BUF && tick |=> st == T_COPY && ee_wr && ee_from_buf && !ee_to_buf)
        else $error("buffer write not followed by copy");
    AST_RECOVER: assert property (@(posedge pclk) disable iff (!presetn)
        st == T_IDLE && !started && nv_pending |=> st == T_REC ##1 ee_from_buf && busy)
        else $error("pending copy not recovered at power-up");
    AST_EXTRA_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ee_to_buf) |-> ee_wr && !done)
        else $error("anti-tearing write missed its second cycle");
endmodule

// file: dv/smsm_reader.sv
// reader model: one command at a time on the card's command handshake
`timescale 1ns/100ps
module smsm_reader
    import smsm_pkg::*;
(
    input wire logic pclk,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output smsm_cmd_t cmd
);
    logic authed = 1'b0;
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    task issue(input smsm_cmd_t c);
        smsm_cmd_t d;
        d = c;
        d.mac_sent = (c.op == OP_WRITE) && authed;
        if (c.op == OP_AUTH || c.op == OP_UNSEL || c.op == OP_QUIET) begin
            authed = (c.op == OP_AUTH) && c.ok;
        end
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd <= d;
        // ready is sampled at the same rising edge at which the card takes the command
        do @(posedge pclk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        // inverse, so a stale command never looks fresh
        cmd <= ~d;
    endtask
endmodule

// file: dv/tb_top.sv
// self-checking bench for the access state manager
`timescale 1ns/100ps
module tb_top;
    import smsm_pkg::*;
    localparam int WR = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic ee_pending = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, cmd_valid, cmd_ready, rsp_valid, pw_cipher, ee_wr, ee_to_buf, ee_from_buf, err, rok;
    smsm_cmd_t cmd, c;
    smsm_rsp_t rsp;
    int fail_count = 0;
    int samples_checked = 0;
    int ncyc, nbuf;
    always #5 pclk = ~pclk;
    smsm_core #(.WR_CYC(WR)) u_smsm_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp, .pw_cipher, .ee_pending, .ee_wr,
        .ee_to_buf, .ee_from_buf);
    smsm_reader u_smsm_reader (.pclk, .cmd_ready, .cmd_valid, .cmd);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("compares %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task st(input logic [31:0] e);
        apb(1'b0, A_STATUS, 32'h0);
        chk(rd, e);
    endtask
    // answer latency counted from the take edge; buffer-zone cycles alongside
    task run(input smsm_op_t op, input logic [3:0] z, input logic k, input logic [5:0] n);
        c.op = op;
        c.zone = z;
        c.ok = k;
        c.len = n;
        u_smsm_reader.issue(c);
        ncyc = 0;
        nbuf = 0;
        #1;
        while (rsp_valid !== 1'b1 && ncyc < 100) begin
            nbuf += int'(ee_to_buf === 1'b1);
            @(posedge pclk);
            #1;
            ncyc++;
        end
        if (ncyc >= 100) begin
            fail_count++;
        end
        rok = rsp.ok;
    endtask
    initial begin
        #60000;
        fail_count++;
        stop_test;
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        c = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        st(32'h0);
        apb(1'b1, A_ZMASK, 32'h0002_0001);
        run(OP_READ, 4'h0, 1'b1, 6'h1);
        chk(rok, 32'h1);
        run(OP_WRITE, 4'h0, 1'b1, 6'h1);
        chk({rok, 31'(ncyc)}, {1'b1, 31'(WR + 1)});
        c.cfg = 1'b1;
        run(OP_READ, 4'h0, 1'b1, 6'h1);
        chk(rok, 32'h0);
        c.pw_val = TRANSPORT_CODE;
        run(OP_CHKPW, 4'h0, 1'b1, 6'h0);
        run(OP_READ, 4'h0, 1'b1, 6'h1);
        chk(rok, 32'h1);
        c = '0;
        run(OP_UNSEL, 4'h0, 1'b1, 6'h0);
        apb(1'b1, A_CTRL, 32'h2);
        apb(1'b0, 8'h14, 32'h0);
        chk(err, 32'h1);
        c.pw_set = 3'h1;
        run(OP_CHKPW, 4'h0, 1'b0, 6'h0);
        apb(1'b0, A_PWCNT, 32'h0);
        chk(rd, 32'h10);
        c.pw_wr = 1'b1;
        run(OP_CHKPW, 4'h0, 1'b1, 6'h0);
        st(32'h98);
        run(OP_READ, 4'h1, 1'b1, 6'h1);
        chk(rok, 32'h1);
        run(OP_UNSEL, 4'h0, 1'b1, 6'h0);
        run(OP_READ, 4'h1, 1'b1, 6'h1);
        chk(rok, 32'h0);
        run(OP_READ, 4'h0, 1'b1, 6'h1);
        chk(rok, 32'h0);
        run(OP_AUTH, 4'h0, 1'b1, 6'h0);
        st(32'h95);
        chk(pw_cipher, 32'h1);
        run(OP_ENC, 4'h0, 1'b1, 6'h0);
        st(32'h97);
        run(OP_READ, 4'h0, 1'b1, 6'h1);
        chk({rok, rsp.crypt}, 32'h3);
        run(OP_ENC, 4'h0, 1'b0, 6'h0);
        run(OP_READ, 4'h0, 1'b1, 6'h1);
        chk(rok, 32'h0);
        run(OP_WRITE, 4'h2, 1'b1, 6'h1);
        chk(rok, 32'h0);
        st(32'h90);
        c.mac_ok = 1'b1;
        run(OP_ENC, 4'h0, 1'b1, 6'h0);
        st(32'h90);
        run(OP_AUTH, 4'h0, 1'b1, 6'h0);
        run(OP_AUTH, 4'h0, 1'b0, 6'h0);
        st(32'h90);
        for (int i = 0; i < 2; i++) begin
            run(OP_AUTH, 4'h0, 1'b1, 6'h0);
            run(OP_ENC, 4'h0, 1'b1, 6'h0);
            run(i ? OP_QUIET : OP_UNSEL, 4'h0, 1'b1, 6'h0);
            st({31'h48, ~rok});
        end
        run(OP_WRITE, 4'h2, 1'b1, 6'h9);
        chk({rok, 31'(ncyc)}, {1'b1, 31'(WR + 1)});
        apb(1'b1, A_CTRL, 32'h3);
        run(OP_WRITE, 4'h2, 1'b1, 6'h9);
        chk(rok, 32'h0);
        run(OP_WRITE, 4'h2, 1'b1, 6'h8);
        chk({rok, 31'(ncyc)}, {1'b1, 31'(2 * WR + 1)});
        chk(nbuf, WR);
        presetn <= 1'b0;
        ee_pending <= 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ee_pending <= 1'b0;
        #1;
        chk({ee_wr, ee_from_buf, cmd_ready}, 32'h6);
        repeat (WR) @(posedge pclk);
        #1;
        chk(ee_wr, 32'h0);
        st(32'h0);
        stop_test;
    end
endmodule
